/* core/fem_pkg.sv */
// Purpose: Shared constants and types for the freeze entry manager.
// Assumes: One system clock of 250 MHz drives all sequencing logic.
// Notes:   Times are kept in their own units; cycle counts derive here.
package fem_pkg;

  // System clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Pin glitch filter: pulses shorter than this are ignored.
  localparam int unsigned GLITCH_NS = 2;
  // A least time, so it rounds up, and never below one cycle.
  localparam int unsigned GLITCH_CYC_RAW =
    (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GLITCH_CYC =
    (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;

  // Entry into the frozen state takes about one microsecond.
  localparam int unsigned ENTRY_US = 1;
  localparam int unsigned ENTRY_CYC =
    (ENTRY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Outputs come back no later than this after the inputs on exit.
  localparam int unsigned OUT_EN_NS = 200;
  // A longest time, so it rounds down, and never below one cycle.
  localparam int unsigned OUT_EN_CYC_RAW =
    (OUT_EN_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned OUT_EN_CYC =
    (OUT_EN_CYC_RAW < 1) ? 1 : OUT_EN_CYC_RAW;

  // Default time that a pin request must persist before it counts.
  localparam int unsigned CONFIRM_CYC_DEF = 8;

  // Largest number of independently gated clocks.
  localparam int unsigned MAX_CLOCKS = 17;

  // Reset levels of the sequencer outputs.
  localparam logic HK_WAIT_RST  = 1'h0;
  localparam logic GATE_N_RST   = 1'h1;
  localparam logic LSC_REQ_RST  = 1'h0;
  localparam logic FRZ_EN_RST   = 1'h0;

  // Sequencer states, fully encoded in three bits.
  typedef enum logic [2:0] {
    FEM_IDLE    = 3'h0,
    FEM_CONFIRM = 3'h1,
    FEM_WAIT_HK = 3'h2,
    FEM_GATE    = 3'h3,
    FEM_LSC_REQ = 3'h4,
    FEM_FROZEN  = 3'h5,
    FEM_EXIT    = 3'h6,
    FEM_RELEASE = 3'h7
  } fem_state_t;

endpackage

/* core/fem_freeze_entry_manager.sv */
// Purpose: Sequence the core into and out of the static freeze mode,
//          with housekeeping handshake, clock gating and the hard
//          freeze block that acts on the request pin.
// Assumes: All inputs are synchronous to mclk_i; each gated clock is
//          represented by a one-cycle tick enable on clk_tick_i.
// Notes:   Gated clocks leave as one-cycle enables, not real clocks.
`timescale 1ns/1ps

module fem_freeze_entry_manager
#(
  parameter int unsigned NUM_CLOCKS  = fem_pkg::MAX_CLOCKS,
  parameter int unsigned CONFIRM_CYC = fem_pkg::CONFIRM_CYC_DEF
)
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic                  freeze_request_pin_n_i,
  input  wire logic                  housekeeping_use_i,
  input  wire logic                  housekeeping_done_i,
  input  wire logic                  hold_state_i,
  input  wire logic                  primary_pll_lock_i,
  input  wire logic [NUM_CLOCKS-1:0] clk_tick_i,
  output logic                       housekeeping_wait_o,
  output logic                       gate_control_n_o,
  output logic                       low_static_current_request_o,
  output logic                       freeze_enabled_o,
  output logic                       frozen_o,
  output logic [NUM_CLOCKS-1:0]      gated_clk_en_o,
  output logic                       ext_clk_tie_high_o,
  output logic                       pll_enable_o,
  output logic                       io_force_high_o,
  output logic                       inputs_active_o,
  output logic                       outputs_enable_o,
  output logic                       jtag_active_o
);

  // Refuse gate counts and confirm times that the logic cannot serve.
  if (NUM_CLOCKS < 1 || NUM_CLOCKS > fem_pkg::MAX_CLOCKS ||
      CONFIRM_CYC < 1 || CONFIRM_CYC > 255)
  begin : g_bad_param
    $error("NUM_CLOCKS must lie in 1..17 and CONFIRM_CYC in 1..255.");
  end

  localparam int unsigned GW = $clog2(fem_pkg::GLITCH_CYC + 1);
  localparam int unsigned EW = $clog2(fem_pkg::ENTRY_CYC + 1);
  localparam int unsigned OW = $clog2(fem_pkg::OUT_EN_CYC + 1);
  localparam logic [GW-1:0] GLITCH_LAST = GW'(fem_pkg::GLITCH_CYC);
  localparam logic [EW-1:0] ENTRY_LAST  = EW'(fem_pkg::ENTRY_CYC - 1);
  localparam logic [OW-1:0] OUT_EN_LAST = OW'(fem_pkg::OUT_EN_CYC - 1);
  localparam logic [7:0]    CONFIRM_LAST = 8'(CONFIRM_CYC - 1);

  // True in the states where the low-current request is held high.
  function automatic logic holds_request(input fem_pkg::fem_state_t s);
    holds_request = (s == fem_pkg::FEM_LSC_REQ) ||
                    (s == fem_pkg::FEM_FROZEN);
  endfunction

  fem_pkg::fem_state_t state;
  fem_pkg::fem_state_t next_state;
  logic [7:0]          confirm_cnt;
  logic                pin_prev;
  logic [GW-1:0]       glitch_cnt;
  logic                pin_filt_n;
  logic [EW-1:0]       entry_cnt;
  logic [OW-1:0]       out_en_cnt;
  logic                freeze_arm;
  logic                request;
  logic                done_eff;
  logic                exit_ready;
  logic [NUM_CLOCKS-1:0] gate_flop;
  logic [NUM_CLOCKS-1:0] gate_latch;
  logic                all_stopped;
  logic                all_open;

  // Pin glitch filter: a new level counts once steady for the filter time.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pin_prev   <= 1'h1;
      glitch_cnt <= '0;
      pin_filt_n <= 1'h1;
    end
    else
    begin
      pin_prev <= freeze_request_pin_n_i;
      if (freeze_request_pin_n_i != pin_prev)
      begin
        glitch_cnt <= '0;
      end
      else if (glitch_cnt != GLITCH_LAST)
      begin
        glitch_cnt <= glitch_cnt + GW'(1);
      end
      else
      begin
        pin_filt_n <= freeze_request_pin_n_i;
      end
    end
  end

  // The pin is active low; the request is the filtered pin inverted.
  assign request    = ~pin_filt_n;
  // The hard block only sees the pin while the request line is high.
  assign freeze_arm = low_static_current_request_o & request;
  // Without housekeeping the wait flag answers itself.
  assign done_eff   = housekeeping_use_i ? housekeeping_done_i
                                         : housekeeping_wait_o;
  // Gates may reopen once inputs are live and the primary clock runs.
  assign exit_ready = inputs_active_o & primary_pll_lock_i;
  assign all_stopped = ~|gate_latch;
  assign all_open    = &gate_latch;

  // Hard freeze block: entry takes about a microsecond of a steady
  // armed condition, and any loss of it leaves freeze at once.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      entry_cnt <= '0;
      frozen_o  <= 1'h0;
    end
    else if (!freeze_arm)
    begin
      entry_cnt <= '0;
      frozen_o  <= 1'h0;
    end
    else if (entry_cnt == ENTRY_LAST)
    begin
      frozen_o <= 1'h1;
    end
    else
    begin
      entry_cnt <= entry_cnt + EW'(1);
    end
  end

  // Pad and clock side effects of freeze. Hold state keeps the pads
  // where they were, so nothing is forced high then.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ext_clk_tie_high_o <= 1'h0;
      io_force_high_o    <= 1'h0;
      pll_enable_o       <= 1'h1;
      jtag_active_o      <= 1'h1;
      inputs_active_o    <= 1'h1;
    end
    else
    begin
      ext_clk_tie_high_o <= frozen_o & ~hold_state_i;
      pll_enable_o       <= ~frozen_o;
      io_force_high_o    <= frozen_o & ~hold_state_i;
      jtag_active_o      <= ~frozen_o;
      inputs_active_o    <= ~frozen_o;
    end
  end

  // Outputs trail the inputs on exit, bounded by the output delay.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      out_en_cnt       <= '0;
      outputs_enable_o <= 1'h1;
    end
    else if (!inputs_active_o)
    begin
      out_en_cnt       <= '0;
      outputs_enable_o <= 1'h0;
    end
    else if (!outputs_enable_o)
    begin
      if (out_en_cnt == OUT_EN_LAST)
      begin
        outputs_enable_o <= 1'h1;
      end
      else
      begin
        out_en_cnt <= out_en_cnt + OW'(1);
      end
    end
  end

  // One gate per clock: a flop samples the gate control on its own
  // clock, a latch passes it while the clock is low, and the AND with
  // the clock forms the buffered output. The latch keeps a change of
  // control from cutting a high phase short.
  for (genvar i = 0; i < NUM_CLOCKS; i++)
  begin : g_gate
    logic tick;
    // A frozen device ties its clock inputs off, so no ticks arrive.
    assign tick = clk_tick_i[i] & ~frozen_o;

    always_ff @(posedge mclk_i)
    begin
      if (rst_i)
      begin
        gate_flop[i]      <= 1'h1;
        gate_latch[i]     <= 1'h1;
        gated_clk_en_o[i] <= 1'h0;
      end
      else
      begin
        if (tick)
        begin
          gate_flop[i] <= gate_control_n_o;
        end
        if (!tick)
        begin
          gate_latch[i] <= gate_flop[i];
        end
        gated_clk_en_o[i] <= tick & gate_latch[i];
      end
    end
  end

  // Next-state decision of the sequencer.
  always_comb
  begin
    next_state = state;
    case (state)
      fem_pkg::FEM_IDLE:
        if (request)
          next_state = fem_pkg::FEM_CONFIRM;
      fem_pkg::FEM_CONFIRM:
        if (!request)
          next_state = fem_pkg::FEM_IDLE;
        else if (confirm_cnt == CONFIRM_LAST)
          next_state = fem_pkg::FEM_WAIT_HK;
      fem_pkg::FEM_WAIT_HK:
        if (!request)
          next_state = fem_pkg::FEM_IDLE;
        else if (done_eff)
          next_state = fem_pkg::FEM_GATE;
      fem_pkg::FEM_GATE:
        if (!request)
          next_state = fem_pkg::FEM_EXIT;
        else if (all_stopped)
          next_state = fem_pkg::FEM_LSC_REQ;
      fem_pkg::FEM_LSC_REQ:
        if (!request)
          next_state = fem_pkg::FEM_EXIT;
        else if (frozen_o)
          next_state = fem_pkg::FEM_FROZEN;
      fem_pkg::FEM_FROZEN:
        if (!request)
          next_state = fem_pkg::FEM_EXIT;
      fem_pkg::FEM_EXIT:
        if (exit_ready)
          next_state = fem_pkg::FEM_RELEASE;
      fem_pkg::FEM_RELEASE:
        if (all_open)
          next_state = fem_pkg::FEM_IDLE;
      default:
        next_state = fem_pkg::FEM_IDLE;
    endcase
  end

  // State register and the persistence counter of the pin request.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state       <= fem_pkg::FEM_IDLE;
      confirm_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == fem_pkg::FEM_CONFIRM)
      begin
        confirm_cnt <= confirm_cnt + 8'h01;
      end
      else
      begin
        confirm_cnt <= '0;
      end
    end
  end

  // Handshake and control outputs, each a flop following the state
  // it is about to enter, so they change together with the state.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      housekeeping_wait_o          <= fem_pkg::HK_WAIT_RST;
      gate_control_n_o             <= fem_pkg::GATE_N_RST;
      low_static_current_request_o <= fem_pkg::LSC_REQ_RST;
      freeze_enabled_o             <= fem_pkg::FRZ_EN_RST;
    end
    else
    begin
      housekeeping_wait_o <=
        (next_state == fem_pkg::FEM_WAIT_HK);
      // Gate control goes low on done and rises only on release.
      if (next_state == fem_pkg::FEM_GATE)
      begin
        gate_control_n_o <= 1'h0;
      end
      else if (next_state == fem_pkg::FEM_RELEASE)
      begin
        gate_control_n_o <= 1'h1;
      end
      // Held for the whole of entry and freeze; dropping it early
      // would pull the device straight back out.
      low_static_current_request_o <=
        holds_request(next_state);
      freeze_enabled_o <= holds_request(next_state);
    end
  end

endmodule

/* testbench/fem_checker_asserts.sv */
// Purpose: Port-level checks on the freeze entry manager.
// Assumes: One clock domain; reset is synchronous and active high.
// Notes:   Attached by bind from the testbench top file.
`timescale 1ns/1ps
module fem_checker
#(
  parameter int unsigned NUM_CLOCKS = fem_pkg::MAX_CLOCKS
)
(
  input wire logic                  mclk_i,
  input wire logic                  rst_i,
  input wire logic                  freeze_request_pin_n_i,
  input wire logic                  housekeeping_use_i,
  input wire logic                  housekeeping_done_i,
  input wire logic                  hold_state_i,
  input wire logic                  primary_pll_lock_i,
  input wire logic                  housekeeping_wait_o,
  input wire logic                  gate_control_n_o,
  input wire logic                  low_static_current_request_o,
  input wire logic                  freeze_enabled_o,
  input wire logic                  frozen_o,
  input wire logic [NUM_CLOCKS-1:0] gated_clk_en_o,
  input wire logic                  ext_clk_tie_high_o,
  input wire logic                  pll_enable_o,
  input wire logic                  io_force_high_o,
  input wire logic                  inputs_active_o,
  input wire logic                  outputs_enable_o,
  input wire logic                  jtag_active_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // A pin low for three samples has certainly passed the filter.
  sequence s_pin_held;
    !freeze_request_pin_n_i [*3];
  endsequence
  sequence s_hk_done;
    housekeeping_wait_o && (housekeeping_done_i || !housekeeping_use_i);
  endsequence

  property p_rst;
    $fell(rst_i) |-> gate_control_n_o && !housekeeping_wait_o &&
      !low_static_current_request_o && !freeze_enabled_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not at reset levels");
  property p_gate;
    s_pin_held ##0 s_hk_done |=> !gate_control_n_o;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate control not lowered after done");
  property p_lsc;
    $rose(low_static_current_request_o) |->
      !gate_control_n_o && gated_clk_en_o == '0;
  endproperty
  a_lsc: assert property (p_lsc)
    else $error("low current request before gating done");
  property p_fen;
    freeze_enabled_o |-> low_static_current_request_o && !gate_control_n_o;
  endproperty
  a_fen: assert property (p_fen)
    else $error("freeze enabled without gating");
  property p_frz;
    $rose(frozen_o) |-> $past(low_static_current_request_o, 2);
  endproperty
  a_frz: assert property (p_frz)
    else $error("frozen without low current request");
  property p_tie;
    ext_clk_tie_high_o == $past(frozen_o && !hold_state_i) &&
      pll_enable_o == !$past(frozen_o);
  endproperty
  a_tie: assert property (p_tie)
    else $error("clock tie or pll enable wrong");
  property p_io;
    io_force_high_o == $past(frozen_o && !hold_state_i);
  endproperty
  a_io: assert property (p_io)
    else $error("io force high wrong");
  property p_jtag;
    jtag_active_o == !$past(frozen_o) && inputs_active_o == jtag_active_o;
  endproperty
  a_jtag: assert property (p_jtag)
    else $error("jtag activity wrong while frozen");
  property p_rel;
    $rose(gate_control_n_o) |-> $past(inputs_active_o && primary_pll_lock_i);
  endproperty
  a_rel: assert property (p_rel)
    else $error("gates released before inputs and pll");
  property p_oe;
    $rose(inputs_active_o) |-> ##[1:50] outputs_enable_o;
  endproperty
  a_oe: assert property (p_oe)
    else $error("outputs not enabled in time");
endmodule

/* testbench/fem_user_model.sv */
// Purpose: User logic that answers the housekeeping handshake.
// Assumes: Drives on the falling edge of the system clock.
// Notes:   DELAY sets how slowly the save work finishes.
`timescale 1ns/1ps
module fem_user_model
#(
  parameter int DELAY = 4
)
(
  input  wire logic mclk_i,
  input  wire logic housekeeping_wait_i,
  output logic      housekeeping_done_o
);
  int cnt = 0;

  // Done drops with wait, so a stale done never leaks into a new request.
  always @(negedge mclk_i)
  begin
    cnt <= housekeeping_wait_i ? cnt + 1 : 0;
    housekeeping_done_o <= housekeeping_wait_i && cnt >= DELAY;
  end
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the freeze entry manager.
// Assumes: Inputs change on falling edges; outputs read there too.
// Notes:   Confirm time shortened to 2 cycles to keep runs short.
`timescale 1ns/1ps
module tb_top;
  localparam int NC = fem_pkg::MAX_CLOCKS;
  logic          mclk_i = 1'h0;
  logic          rst_i  = 1'h1;
  logic          pin_n  = 1'h1;
  logic          use_hk = 1'h1;
  logic          hold   = 1'h0;
  logic          lock   = 1'h1;
  logic          tick   = 1'h0;
  logic          done;
  logic          wait_o, gate_n, lsc, fen, frozen;
  logic          tie, pll_en, io_hi, in_act, out_en, jtag;
  logic [NC-1:0] gclk;
  int            fail_count = 0;
  int            n_tests    = 0;

  fem_freeze_entry_manager #(.CONFIRM_CYC(2)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .freeze_request_pin_n_i(pin_n),
    .housekeeping_use_i(use_hk), .housekeeping_done_i(done),
    .hold_state_i(hold), .primary_pll_lock_i(lock),
    .clk_tick_i({NC{tick}}), .housekeeping_wait_o(wait_o),
    .gate_control_n_o(gate_n), .low_static_current_request_o(lsc),
    .freeze_enabled_o(fen), .frozen_o(frozen), .gated_clk_en_o(gclk),
    .ext_clk_tie_high_o(tie), .pll_enable_o(pll_en),
    .io_force_high_o(io_hi), .inputs_active_o(in_act),
    .outputs_enable_o(out_en), .jtag_active_o(jtag));
  fem_user_model #(.DELAY(4)) user (
    .mclk_i(mclk_i), .housekeeping_wait_i(wait_o),
    .housekeeping_done_o(done));

  initial forever #2 mclk_i = ~mclk_i;
  // Ticks every other cycle, so the gate latches get cycles to follow.
  always @(negedge mclk_i) tick <= ~tick;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = wait_o;
      1: pick = gate_n;
      2: pick = lsc;
      3: pick = frozen;
      default: pick = out_en;
    endcase
  endfunction

  // Bounded wait for an output to reach a level; running out fails.
  task automatic await(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(s) !== v && k < lim)
    begin
      @(negedge mclk_i);
      k++;
    end
    if (pick(s) !== v)
    begin
      fail_count++;
      conclude();
    end
  endtask

  // One full entry and exit; the pll is held off to delay the release.
  task automatic run(input logic hk, input logic hs);
    use_hk = hk;
    hold = hs;
    pin_n = 1'h0;
    await(0, 1'h1, 30);
    @(negedge mclk_i);
    chk(gate_n, hk);
    await(1, 1'h0, 20);
    await(2, 1'h1, 40);
    chk(fen, 1'h1);
    chk(gclk, {NC{1'h0}});
    await(3, 1'h1, 300);
    chk(lsc, 1'h1);
    repeat (2) @(negedge mclk_i);
    chk({tie, io_hi, pll_en, jtag, in_act},
        {~hs, ~hs, 3'h0});
    lock = 1'h0;
    pin_n = 1'h1;
    repeat (20) @(negedge mclk_i);
    chk({gate_n, lsc, fen, frozen, out_en}, 5'h00);
    lock = 1'h1;
    await(1, 1'h1, 10);
    await(4, 1'h1, 50);
    repeat (4) @(negedge mclk_i);
    chk(gclk, {NC{tick}});
  endtask

  initial
  begin
    repeat (5) @(negedge mclk_i);
    rst_i = 1'h0;
    @(negedge mclk_i);
    chk({wait_o, gate_n, lsc, fen, frozen, pll_en, out_en, jtag},
        8'h47);
    chk(gclk, {NC{tick}});
    pin_n = 1'h0;
    @(negedge mclk_i);
    pin_n = 1'h1;
    repeat (15) @(negedge mclk_i);
    chk(wait_o, 1'h0);
    run(1'h1, 1'h0);
    run(1'h0, 1'h1);
    // A request dropped while housekeeping runs must leave no trace.
    use_hk = 1'h1;
    pin_n = 1'h0;
    await(0, 1'h1, 30);
    pin_n = 1'h1;
    repeat (6) @(negedge mclk_i);
    chk({wait_o, gate_n, lsc, fen}, 4'h4);
    conclude();
  end
endmodule

bind fem_freeze_entry_manager fem_checker #(.NUM_CLOCKS(NUM_CLOCKS))
  chk_i (.*);
